/* common/ospl_pkg.sv */
// Package: encodings, reset values and division constants for the clock selector
package ospl_pkg;

    // ------------------------------------------------------------
    // Initial oscillator select encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OSPL_SRC_FAST       = 3'h0,
        OSPL_SRC_FAST_PLL   = 3'h1,
        OSPL_SRC_PRI        = 3'h2,
        OSPL_SRC_PRI_PLL    = 3'h3,
        OSPL_SRC_SEC        = 3'h4,
        OSPL_SRC_LOWP       = 3'h5,
        OSPL_SRC_FAST_DIV16 = 3'h6,
        OSPL_SRC_FAST_DIVN  = 3'h7
    } ospl_src_type;

    // ------------------------------------------------------------
    // Primary submode encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OSPL_PRI_EC  = 2'h0,
        OSPL_PRI_XT  = 2'h1,
        OSPL_PRI_HS  = 2'h2,
        OSPL_PRI_RSV = 2'h3
    } ospl_pri_type;

    // ------------------------------------------------------------
    // Field widths and reset values
    // ------------------------------------------------------------
    localparam int          OSPL_CNT_W        = 10;
    localparam logic [2:0]  OSPL_ERASED_SEL   = 3'h7;
    localparam logic [1:0]  OSPL_POST_DIV2    = 2'h0;
    localparam logic [1:0]  OSPL_POST_DIV4    = 2'h1;
    localparam logic [1:0]  OSPL_POST_RSV     = 2'h2;
    localparam logic [1:0]  OSPL_POST_DIV8    = 2'h3;
    localparam logic [2:0]  OSPL_FAST_DIV256  = 3'h7;
    localparam logic [2:0]  OSPL_FAST_DIV16   = 3'h4;
    localparam logic [9:0]  OSPL_PRE_OFFSET   = 10'h002;
    localparam logic [9:0]  OSPL_FB_OFFSET    = 10'h002;
    localparam logic [9:0]  OSPL_LOG_DIV256   = 10'h008;
    localparam logic [9:0]  OSPL_FCY_DIV      = 10'h002;
    localparam logic [1:0]  OSPL_SETTLE_CYC   = 2'h3;

endpackage

/* common/ospl_div_if.sv */
// Interface: request and result of one clock divider stage
`timescale 1ns/100ps
`default_nettype none
interface ospl_div_if;
    logic       tick_in;   // Input clock event
    logic [9:0] ratio;     // Divide ratio, at least 1
    logic       tick_out;  // Output clock event
    logic       level;     // Divided square wave

    // Stage side
    modport stage (input tick_in, input ratio, output tick_out, output level);
    // User side
    modport user (output tick_in, output ratio, input tick_out, input level);
endinterface
`default_nettype wire

/* core/ospl_divider.sv */
// Divider stage: counts input ticks and emits one tick per ratio
`timescale 1ns/100ps
`default_nettype none
module ospl_divider
    import ospl_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Divider carrier
    ospl_div_if.stage dv
);
    // ------------------------------------------------------------
    // Counter state
    // ------------------------------------------------------------
    logic [9:0] cnt_ff;       // Ticks seen in this period
    logic [9:0] nxt_cnt;      // Next count
    logic       tick_ff;      // Output tick
    logic       nxt_tick;     // Next output tick
    logic       level_ff;     // Square wave output
    logic       nxt_level;    // Next square wave

    assign dv.tick_out = tick_ff;
    assign dv.level    = level_ff;

    // Next state: wrap at ratio, toggle level at half and end
    always_comb begin
        nxt_cnt   = cnt_ff;
        nxt_tick  = 1'b0;
        nxt_level = level_ff;
        if (dv.tick_in) begin
            if (cnt_ff + 10'h001 >= dv.ratio) begin
                nxt_cnt   = '0;
                nxt_tick  = 1'b1;
                nxt_level = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 10'h001;
                if (nxt_cnt >= (dv.ratio >> 1)) begin
                    nxt_level = 1'b0;
                end
            end
        end
    end

    // Register stage
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_ff   <= '0;
            tick_ff  <= 1'b0;
            level_ff <= 1'b0;
        end else begin
            cnt_ff   <= nxt_cnt;
            tick_ff  <= nxt_tick;
            level_ff <= nxt_level;
        end
    end
endmodule
`default_nettype wire

/* core/ospl_clock_select.sv */
// Clock source selector with PLL factor and fast RC postscaler logic
`timescale 1ns/100ps
`default_nettype none

module ospl_clock_select
    import ospl_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Source clock events, one-cycle pulses
    input  wire logic        fast_rc_osc_tick,
    input  wire logic        primary_osc_tick,
    input  wire logic        secondary_osc_tick,
    input  wire logic        low_power_rc_osc_tick,
    input  wire logic        pll_vco_tick,
    // Nonvolatile configuration straps
    input  wire logic [2:0]  initial_osc_sel,
    input  wire logic [1:0]  primary_osc_submode,
    input  wire logic        osc2_pin_function_cfg,
    // Software controls
    input  wire logic [2:0]  fast_rc_postscale_sel,
    input  wire logic [4:0]  pll_input_div_sel,
    input  wire logic [8:0]  pll_feedback_mult_sel,
    input  wire logic [1:0]  pll_output_div_sel,
    input  wire logic [5:0]  fast_rc_tune,
    // Status and derived clocks
    output logic [2:0]       current_osc,
    output logic [1:0]       current_submode,
    output logic             pll_active,
    output logic [5:0]       fast_rc_trim,
    output logic [9:0]       prescale_factor,
    output logic [9:0]       feedback_factor,
    output logic [9:0]       postscale_factor,
    output logic             pll_input_clock,
    output logic             osc_clock_tick,
    output logic             instr_clock,
    output logic             ref_clock_tick,
    output logic             osc2_is_gpio,
    output logic             dependent_rst
);
    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------
    // Fast RC postscale ratio
    function automatic logic [9:0] fast_ratio(input logic [2:0] sel);
        if (sel == OSPL_FAST_DIV256) begin
            fast_ratio = 10'h001 << OSPL_LOG_DIV256;
        end else begin
            fast_ratio = 10'h001 << sel;
        end
    endfunction

    // PLL postscale ratio; reserved code holds the divide by 4
    function automatic logic [9:0] post_ratio(input logic [1:0] sel);
        unique case (sel)
            OSPL_POST_DIV2: post_ratio = 10'h002;
            OSPL_POST_DIV8: post_ratio = 10'h008;
            default:        post_ratio = 10'h004;
        endcase
    endfunction

    // Source uses the PLL
    function automatic logic uses_pll(input logic [2:0] s);
        uses_pll = (s == OSPL_SRC_FAST_PLL) || (s == OSPL_SRC_PRI_PLL);
    endfunction

    // ------------------------------------------------------------
    // Start-up sequence state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OSPL_ST_LOAD,
        OSPL_ST_SETTLE,
        OSPL_ST_RUN
    } ospl_state_type;

    ospl_state_type state_ff;       // Start-up state
    ospl_state_type nxt_state;      // Next state
    logic [2:0]     src_ff;         // Latched source
    logic [2:0]     nxt_src;        // Next source
    logic [1:0]     sub_ff;         // Latched submode
    logic [1:0]     nxt_sub;        // Next submode
    logic           pin_ff;         // Latched pin function
    logic           nxt_pin;        // Next pin function
    logic [1:0]     settle_ff;      // Settle counter
    logic [1:0]     nxt_settle;     // Next settle count
    logic           drst_ff;        // Dependent reset
    logic           nxt_drst;       // Next dependent reset
    logic           osc_tick;       // Selected oscillator output event
    logic           pll_src;        // Raw clock into the PLL

    // Next state: catch straps after release, then wait for source
    always_comb begin
        nxt_state  = state_ff;
        nxt_src    = src_ff;
        nxt_sub    = sub_ff;
        nxt_pin    = pin_ff;
        nxt_settle = settle_ff;
        nxt_drst   = drst_ff;
        unique case (state_ff)
            OSPL_ST_LOAD: begin
                nxt_src   = initial_osc_sel;
                nxt_sub   = primary_osc_submode;
                nxt_pin   = osc2_pin_function_cfg;
                nxt_state = OSPL_ST_SETTLE;
            end
            OSPL_ST_SETTLE: begin
                // Count source ticks so the selection really drives out
                if (osc_tick) begin
                    nxt_settle = settle_ff + 2'h1;
                end
                if (settle_ff == OSPL_SETTLE_CYC) begin
                    nxt_state = OSPL_ST_RUN;
                    nxt_drst  = 1'b0;
                end
            end
            OSPL_ST_RUN: begin
                nxt_drst = 1'b0;
            end
        endcase
    end

    // Register start-up state; erased-strap default before load
    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff  <= OSPL_ST_LOAD;
            src_ff    <= OSPL_ERASED_SEL;
            sub_ff    <= OSPL_PRI_EC;
            pin_ff    <= 1'b0;
            settle_ff <= '0;
            drst_ff   <= 1'b1;
        end else begin
            state_ff  <= nxt_state;
            src_ff    <= nxt_src;
            sub_ff    <= nxt_sub;
            pin_ff    <= nxt_pin;
            settle_ff <= nxt_settle;
            drst_ff   <= nxt_drst;
        end
    end

    // ------------------------------------------------------------
    // Fast RC postscaler and divide-by-16 stage
    // ------------------------------------------------------------
    ospl_div_if fast_dv ();
    assign fast_dv.tick_in = fast_rc_osc_tick;
    assign fast_dv.ratio   = (src_ff == OSPL_SRC_FAST_DIV16) ? fast_ratio(OSPL_FAST_DIV16)
                                                             : fast_ratio(fast_rc_postscale_sel);
    ospl_divider u_fast_div (
        .clock (clock),
        .rst   (rst),
        .dv    (fast_dv)
    );

    // PLL output postscaler carrier on VCO ticks, ahead of the multiplexer that reads it
    ospl_div_if post_dv ();
    assign post_dv.tick_in = pll_vco_tick;
    assign post_dv.ratio   = post_ratio(pll_output_div_sel);

    // ------------------------------------------------------------
    // Source multiplexer
    // ------------------------------------------------------------
    // Pick the oscillator output; PLL modes use the VCO path
    always_comb begin
        pll_src = (src_ff == OSPL_SRC_PRI_PLL) ? primary_osc_tick : fast_rc_osc_tick;
        unique case (src_ff)
            OSPL_SRC_FAST:       osc_tick = fast_rc_osc_tick;
            OSPL_SRC_PRI:        osc_tick = primary_osc_tick;
            OSPL_SRC_SEC:        osc_tick = secondary_osc_tick;
            OSPL_SRC_LOWP:       osc_tick = low_power_rc_osc_tick;
            OSPL_SRC_FAST_DIV16: osc_tick = fast_dv.tick_out;
            OSPL_SRC_FAST_DIVN:  osc_tick = fast_dv.tick_out;
            default:            osc_tick = post_dv.tick_out;
        endcase
    end

    // ------------------------------------------------------------
    // Instruction clock halver on oscillator ticks
    // ------------------------------------------------------------
    ospl_div_if fcy_dv ();
    assign fcy_dv.tick_in  = osc_tick;
    assign fcy_dv.ratio    = OSPL_FCY_DIV;
    ospl_divider u_fcy_div (
        .clock (clock),
        .rst   (rst),
        .dv    (fcy_dv)
    );

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    logic [9:0] nxt_pre;    // Prescale factor
    logic [9:0] nxt_fb;     // Feedback factor
    logic [9:0] nxt_post;   // Postscale factor

    // Factor arithmetic for the analog loop: out = in * feedback / (prescale * postscale)
    always_comb begin
        nxt_pre  = {5'h00, pll_input_div_sel} + OSPL_PRE_OFFSET;
        nxt_fb   = {1'b0, pll_feedback_mult_sel} + OSPL_FB_OFFSET;
        nxt_post = post_ratio(pll_output_div_sel);
    end

    // Register every output; dividers restart with the block
    always_ff @(posedge clock) begin
        if (rst) begin
            current_osc      <= OSPL_ERASED_SEL;
            current_submode  <= OSPL_PRI_EC;
            pll_active       <= 1'b0;
            fast_rc_trim     <= '0;
            prescale_factor  <= OSPL_PRE_OFFSET;
            feedback_factor  <= OSPL_FB_OFFSET;
            postscale_factor <= post_ratio(OSPL_POST_DIV4);
            pll_input_clock  <= 1'b0;
            osc_clock_tick   <= 1'b0;
            instr_clock      <= 1'b0;
            ref_clock_tick   <= 1'b0;
            osc2_is_gpio     <= 1'b0;
            dependent_rst    <= 1'b1;
        end else begin
            current_osc      <= src_ff;
            current_submode  <= sub_ff;
            pll_active       <= uses_pll(src_ff);
            fast_rc_trim     <= fast_rc_tune;
            prescale_factor  <= nxt_pre;
            feedback_factor  <= nxt_fb;
            postscale_factor <= nxt_post;
            pll_input_clock  <= uses_pll(src_ff) & pll_src;
            osc_clock_tick   <= osc_tick;
            instr_clock      <= fcy_dv.level;
            ref_clock_tick   <= low_power_rc_osc_tick;
            osc2_is_gpio     <= pin_ff;
            dependent_rst    <= drst_ff;
        end
    end

    ospl_divider u_post_div (
        .clock (clock),
        .rst   (rst),
        .dv    (post_dv)
    );
endmodule
`default_nettype wire

/* tb/ospl_osc_model.sv */
// Partner model: free-running oscillator event sources for the clock selector
`timescale 1ns/100ps
`default_nettype none
module ospl_osc_model #(
    parameter int P_FAST = 2,  // Fast RC event period in system cycles
    parameter int P_PRI  = 3,  // Primary crystal event period
    parameter int P_SEC  = 7,  // Secondary crystal event period
    parameter int P_LOWP = 11, // Low-power RC event period
    parameter int P_VCO  = 5   // VCO event period
) (
    // System clock
    input  wire logic clock,
    // Oscillator events, one-cycle pulses
    output logic      fast_rc_osc_tick,
    output logic      primary_osc_tick,
    output logic      secondary_osc_tick,
    output logic      low_power_rc_osc_tick,
    output logic      pll_vco_tick
);
    int cyc; // Free-running cycle count

    // Sources run free; each event moves just after the edge
    always @(posedge clock) begin
        #1;
        cyc = cyc + 1;
        fast_rc_osc_tick = (cyc % P_FAST) == 0;
        primary_osc_tick = (cyc % P_PRI) == 0;
        secondary_osc_tick = (cyc % P_SEC) == 0;
        low_power_rc_osc_tick = (cyc % P_LOWP) == 0;
        pll_vco_tick = (cyc % P_VCO) == 0;
    end

    // Quiet lines at time zero
    initial begin
        cyc = 0;
        {fast_rc_osc_tick, primary_osc_tick, secondary_osc_tick} = 3'h0;
        {low_power_rc_osc_tick, pll_vco_tick} = 2'h0;
    end
endmodule
`default_nettype wire

/* tb/ospl_clock_select_assertions.sv */
// Checker: port-level properties of the clock selector
`timescale 1ns/100ps
`default_nettype none
module ospl_clock_select_assertions
    import ospl_pkg::*;
(
    // Clock, reset and inputs
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       low_power_rc_osc_tick,
    input wire logic [4:0] pll_input_div_sel,
    input wire logic [8:0] pll_feedback_mult_sel,
    input wire logic [1:0] pll_output_div_sel,
    input wire logic [5:0] fast_rc_tune,
    // Outputs under watch
    input wire logic [2:0] current_osc,
    input wire logic [1:0] current_submode,
    input wire logic       pll_active,
    input wire logic [5:0] fast_rc_trim,
    input wire logic [9:0] prescale_factor,
    input wire logic [9:0] feedback_factor,
    input wire logic [9:0] postscale_factor,
    input wire logic       pll_input_clock,
    input wire logic       ref_clock_tick,
    input wire logic       osc2_is_gpio,
    input wire logic       dependent_rst
);
    logic [2:0] rel_ff;  // Cycles since reset release, saturating at 4
    logic [2:0] nxt_rel;

    // Count settles after release so checks skip reset residue
    always_comb nxt_rel = rst ? 3'h0 : (rel_ff == 3'h4 ? rel_ff : rel_ff + 3'h1);
    always_ff @(posedge clock) rel_ff <= nxt_rel;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_PRE_FACTOR: assert property (rel_ff != 3'h0 |->
        prescale_factor == {5'h00, $past(pll_input_div_sel)} + 10'h002) else $error("prescale factor wrong");
    AST_FB_FACTOR: assert property (rel_ff != 3'h0 |->
        feedback_factor == {1'b0, $past(pll_feedback_mult_sel)} + 10'h002) else $error("feedback factor wrong");
    AST_POST_FACTOR: assert property (rel_ff != 3'h0 |-> postscale_factor ==
        ($past(pll_output_div_sel) == 2'h3 ? 10'h008 : $past(pll_output_div_sel) == 2'h0 ? 10'h002 : 10'h004))
        else $error("postscale factor wrong");
    AST_TRIM: assert property (rel_ff != 3'h0 |-> fast_rc_trim == $past(fast_rc_tune))
        else $error("trim not passed");
    AST_REF_TICK: assert property (rel_ff != 3'h0 |-> ref_clock_tick == $past(low_power_rc_osc_tick))
        else $error("reference tick wrong");
    AST_ERASED_START: assert property ($fell(rst) |-> current_osc == 3'h7 && dependent_rst)
        else $error("reset source or hold wrong");
    AST_STRAP_HOLD: assert property (rel_ff == 3'h4 |->
        $stable(current_osc) && $stable(current_submode) && $stable(osc2_is_gpio)) else $error("straps moved");
    AST_PLL_ONLY: assert property (rel_ff == 3'h4 |-> pll_active == (current_osc == 3'h1 || current_osc == 3'h3)
        && (pll_active || !pll_input_clock)) else $error("pll on wrong source");
    AST_DEP_HOLD: assert property (!dependent_rst |=> !dependent_rst)
        else $error("dependent reset rose");
    AST_DEP_BOUND: assert property ($fell(rst) |-> ##[1:300] !dependent_rst)
        else $error("dependent reset stuck");

    cover property (pll_active && pll_input_clock);
    cover property ($fell(dependent_rst));
    cover property (postscale_factor == 10'h008);
endmodule

bind ospl_clock_select ospl_clock_select_assertions chk (.clock(clock), .rst(rst),
    .low_power_rc_osc_tick(low_power_rc_osc_tick), .pll_input_div_sel(pll_input_div_sel),
    .pll_feedback_mult_sel(pll_feedback_mult_sel), .pll_output_div_sel(pll_output_div_sel),
    .fast_rc_tune(fast_rc_tune), .current_osc(current_osc), .current_submode(current_submode),
    .pll_active(pll_active), .fast_rc_trim(fast_rc_trim), .prescale_factor(prescale_factor),
    .feedback_factor(feedback_factor), .postscale_factor(postscale_factor),
    .pll_input_clock(pll_input_clock), .ref_clock_tick(ref_clock_tick), .osc2_is_gpio(osc2_is_gpio),
    .dependent_rst(dependent_rst));
`default_nettype wire

/* tb/oscillator_select_pll_config_tb_top.sv */
// Testbench: strap decode, source routing, dividers and factor decode
`timescale 1ns/100ps
`default_nettype none
module oscillator_select_pll_config_tb_top
    import ospl_pkg::*;
;
    logic            clock, rst, gpio_cfg;                  // Clock, reset, pin strap
    logic [2:0]      osc_sel, fast_div;                     // Source strap, fast RC divide
    logic [1:0]      submode, post_sel;                     // Submode strap, postscale select
    logic [4:0]      pre_sel;                               // Prescale select
    logic [8:0]      fb_sel;                                // Feedback select
    logic [5:0]      tune;                                  // Fast RC trim request
    wire logic       f_tk, p_tk, s_tk, l_tk, v_tk;          // Source events
    wire logic       pll_act, pll_in, osc_tk, ins, ref_tk;  // Derived clocks
    wire logic       gpio, dep_rst;                         // Pin mode, dependent hold
    wire logic [2:0] cur_osc;                               // Latched source
    wire logic [1:0] cur_sm;                                // Latched submode
    wire logic [5:0] trim;                                  // Trim copy
    wire logic [9:0] pre_f, fb_f, post_f;                   // Decoded factors
    int              failures, checks_done;                 // Mismatch and compare counts

    ospl_osc_model model (.clock(clock), .fast_rc_osc_tick(f_tk), .primary_osc_tick(p_tk),
        .secondary_osc_tick(s_tk), .low_power_rc_osc_tick(l_tk), .pll_vco_tick(v_tk));
    ospl_clock_select dut (.clock(clock), .rst(rst), .fast_rc_osc_tick(f_tk), .primary_osc_tick(p_tk),
        .secondary_osc_tick(s_tk), .low_power_rc_osc_tick(l_tk), .pll_vco_tick(v_tk),
        .initial_osc_sel(osc_sel), .primary_osc_submode(submode), .osc2_pin_function_cfg(gpio_cfg),
        .fast_rc_postscale_sel(fast_div), .pll_input_div_sel(pre_sel), .pll_feedback_mult_sel(fb_sel),
        .pll_output_div_sel(post_sel), .fast_rc_tune(tune), .current_osc(cur_osc), .current_submode(cur_sm),
        .pll_active(pll_act), .fast_rc_trim(trim), .prescale_factor(pre_f), .feedback_factor(fb_f),
        .postscale_factor(post_f), .pll_input_clock(pll_in), .osc_clock_tick(osc_tk), .instr_clock(ins),
        .ref_clock_tick(ref_tk), .osc2_is_gpio(gpio), .dependent_rst(dep_rst));

    // 10 MHz system clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Compare one value and count it
    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Rate compare allowing one event of phase slip
    task automatic chk_near(string what, int seen, int exp);
        chk(what, 16'((seen - exp <= 1 && exp - seen <= 1) ? exp : seen), 16'(exp));
    endtask

    // Print counts and verdict, then stop
    task automatic end_sim;
        $display("Checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Reset for 8 cycles with the given straps
    task automatic do_reset(logic [2:0] sel, logic [1:0] sm, logic g);
        @(posedge clock); #1;
        rst = 1'b1;
        osc_sel = sel;
        submode = sm;
        gpio_cfg = g;
        repeat (8) @(posedge clock);
        #1 rst = 1'b0;
        repeat (4) @(posedge clock);
        #1;
    endtask

    // Count oscillator events, instruction clock toggles and PLL input events
    task automatic count_ticks(int w, output int no, output int ni, output int np);
        logic prev;
        no = 0;
        ni = 0;
        np = 0;
        prev = ins;
        repeat (w) begin
            @(posedge clock); #1;
            no += int'(osc_tk);
            np += int'(pll_in);
            ni += int'(ins !== prev);
            prev = ins;
        end
    endtask

    // Factor decode at boundary and reserved codes
    task automatic t_factors;
        int pre_t [4] = '{0, 31, 16, 5};
        int fb_t [4] = '{0, 511, 30, 48};
        int post_e [4] = '{2, 4, 4, 8};
        for (int i = 0; i < 4; i++) begin
            pre_sel = 5'(pre_t[i]);
            fb_sel = 9'(fb_t[i]);
            post_sel = 2'(i);
            tune = 6'(i + 29);
            repeat (2) @(posedge clock);
            #1;
            chk("prescale_factor", 16'(pre_f), 16'(pre_t[i] + 2));
            chk("feedback_factor", 16'(fb_f), 16'(fb_t[i] + 2));
            chk("postscale_factor", 16'(post_f), 16'(post_e[i]));
            chk("fast_rc_trim", 16'(trim), 16'(i + 29));
        end
        pre_sel = 5'h00;
        fb_sel = 9'h01e;
        post_sel = 2'h1;
        $display("t_factors done");
    endtask

    // Strap codes 0 to 6: latched status, routed source rate and PLL gating
    task automatic t_sources;
        int sel_t [9] = '{0, 1, 2, 2, 2, 3, 4, 5, 6};
        int sm_t [9] = '{3, 1, 0, 1, 2, 2, 0, 2, 1};
        int osc_t [9] = '{2, 20, 3, 3, 3, 20, 7, 11, 32};
        int pll_t [9] = '{0, 2, 0, 0, 0, 3, 0, 0, 0};
        int no, ni, np;
        for (int k = 0; k < 9; k++) begin
            do_reset(3'(sel_t[k]), 2'(sm_t[k]), k[0]);
            osc_sel = ~osc_sel;
            count_ticks(2310, no, ni, np);
            chk("current_osc", 16'(cur_osc), 16'(sel_t[k]));
            chk("current_submode", 16'(cur_sm), 16'(sm_t[k]));
            chk("pll_active", 16'(pll_act), 16'(pll_t[k] != 0));
            chk("osc2_is_gpio", 16'(gpio), 16'(k[0]));
            chk("dependent_rst", 16'(dep_rst), 16'h0000);
            chk_near("osc_ticks", no, 2310 / osc_t[k]);
            chk_near("instr_toggles", ni, no);
            chk_near("pll_in_ticks", np, pll_t[k] == 0 ? 0 : 2310 / pll_t[k]);
        end
        $display("t_sources done");
    endtask

    // Erased straps and every fast RC postscale code
    task automatic t_fast_div;
        int div_t [8] = '{1, 2, 4, 8, 16, 32, 64, 256};
        int no, ni, np;
        do_reset(OSPL_ERASED_SEL, 2'h0, 1'b0);
        chk("erased_osc", 16'(cur_osc), 16'h0007);
        for (int d = 0; d < 8; d++) begin
            fast_div = 3'(d);
            count_ticks(5120, no, ni, np);
            chk_near("fast_div_ticks", no, 5120 / (2 * div_t[d]));
        end
        fast_div = 3'h0;
        $display("t_fast_div done");
    endtask

    // Main sequence
    initial begin
        {failures, checks_done} = '0;
        {rst, gpio_cfg, osc_sel, submode} = {1'b1, 1'b0, OSPL_ERASED_SEL, 2'h0};
        {fast_div, pre_sel, fb_sel, post_sel, tune} = {3'h0, 5'h00, 9'h01e, 2'h1, 6'h00};
        do_reset(OSPL_ERASED_SEL, 2'h0, 1'b0);
        t_factors();
        t_sources();
        t_fast_div();
        end_sim();
    end

    // Watchdog for a hung run
    initial begin
        repeat (90000) @(posedge clock);
        failures++;
        $display("[ERR] watchdog expected done seen timeout");
        end_sim();
    end
endmodule
`default_nettype wire
